// *** rtl/lhb_host_if.sv ***
// host bus front end: parallel strobe, enable strobe and serial ports
`timescale 1ns/1ps
`default_nettype none
module lhb_host_if
   import lhb_pkg::*;
(
   input wire logic clk,
   input wire logic rst,
   input wire logic init_low,
   input wire logic chip_select_low_active,
   input wire logic chip_select_high_active,
   input wire logic data_command_select,
   input wire logic rd_strobe,
   input wire logic wr_strobe,
   input wire logic port_kind_select,
   input wire logic bus_style_select,
   input wire logic osc_source_select,
   input wire logic temp_slope_select,
   input wire logic reference_origin_select,
   input wire logic dot_timing_pin,
   input wire logic [7:0] host_data_bus_in,
   output logic [7:0] host_data_bus_out,
   output logic [7:0] host_data_bus_oe_n,
   input wire logic [7:0] read_data,
   output logic read_req,
   output logic wr_valid,
   output logic [7:0] wr_data,
   output logic wr_is_data,
   output logic settings_init,
   output logic dot_clk_en,
   output logic osc_enable,
   output logic slope_steep,
   output logic ref_internal
);
   // pin synchronisers
   logic [14:0] pins_q;
   lhb_sync #(.W(15)) u_sync (
      .clk(clk),
      .rst(rst),
      .d({host_data_bus_in, init_low, chip_select_low_active,
          chip_select_high_active, data_command_select, rd_strobe,
          wr_strobe, dot_timing_pin}),
      .q(pins_q)
   );
   logic [7:0] bus_s;
   logic init_n_s, csl_s, csh_s, dc_s, rd_s, wr_s, dot_s;
   assign bus_s = pins_q[14:7];
   assign init_n_s = pins_q[6];
   assign csl_s = pins_q[5];
   assign csh_s = pins_q[4];
   assign dc_s = pins_q[3];
   assign rd_s = pins_q[2];
   assign wr_s = pins_q[1];
   assign dot_s = pins_q[0];

   // strap synchronisers; straps are pins too, so no raw level reaches logic
   logic [4:0] straps_q;
   lhb_sync #(.W(5)) u_strap (
      .clk(clk),
      .rst(rst),
      .d({port_kind_select, bus_style_select, osc_source_select,
          temp_slope_select, reference_origin_select}),
      .q(straps_q)
   );
   logic par_s, style_s, osc_s, slope_s, ref_s;
   assign par_s = straps_q[4];
   assign style_s = straps_q[3];
   assign osc_s = straps_q[2];
   assign slope_s = straps_q[1];
   assign ref_s = straps_q[0];

   function automatic logic rising(input logic prev, input logic cur);
      return cur & ~prev;
   endfunction

   // state
   logic rd_d_r, rd_d_nxt, wr_d_r, wr_d_nxt, scl_d_r, scl_d_nxt;
   logic dot_d_r, dot_d_nxt;
   logic [7:0] sh_r, sh_nxt;
   logic [2:0] cnt_r, cnt_nxt;
   lhb_pstate_t st_r, st_nxt;
   logic [7:0] out_r, out_nxt, oe_n_r, oe_n_nxt;
   logic rreq_r, rreq_nxt, wv_r, wv_nxt, wid_r, wid_nxt;
   logic [7:0] wd_r, wd_nxt;
   logic init_r, init_nxt;
   logic [1:0] div_r, div_nxt;
   logic dce_r, dce_nxt;
   logic osc_r, osc_nxt, slope_r, slope_nxt, ref_r, ref_nxt;

   logic cs_on, par, estyle, in_init;

   always_comb begin
      cs_on = ~csl_s & csh_s;
      par = par_s;
      estyle = style_s;
      in_init = ~init_n_s;
      rd_d_nxt = rd_s;
      wr_d_nxt = wr_s;
      scl_d_nxt = bus_s[LHB_SCL_BIT];
      dot_d_nxt = dot_s;
      sh_nxt = sh_r;
      cnt_nxt = cnt_r;
      st_nxt = st_r;
      out_nxt = out_r;
      oe_n_nxt = LHB_OE_ALL_OFF;
      rreq_nxt = 1'b0;
      wv_nxt = 1'b0;
      wd_nxt = wd_r;
      wid_nxt = wid_r;
      init_nxt = in_init;
      osc_nxt = osc_s;
      slope_nxt = slope_s;
      ref_nxt = ref_s;
      div_nxt = div_r;
      dce_nxt = 1'b0;
      // display dot timing source
      if (osc_s) begin
         div_nxt = div_r + 2'h1;
         dce_nxt = (div_r == 2'(LHB_OSC_DIV - 1));
      end else begin
         div_nxt = 2'h0;
         dce_nxt = rising(dot_d_r, dot_s);
      end
      if (in_init || !cs_on) begin
         cnt_nxt = 3'h0;
         st_nxt = LHB_IDLE;
         sh_nxt = LHB_DATA_RST;
      end else if (!par) begin
         // serial, write only; no output enable ever set here
         if (rising(scl_d_r, bus_s[LHB_SCL_BIT])) begin
            sh_nxt = {sh_r[6:0], bus_s[LHB_SI_BIT]};
            cnt_nxt = cnt_r + 3'h1;
            if (cnt_r == LHB_BITS_LAST) begin
               wv_nxt = 1'b1;
               wd_nxt = {sh_r[6:0], bus_s[LHB_SI_BIT]};
               wid_nxt = dc_s;
            end
         end
      end else if (!estyle) begin
         if (!rd_s) begin
            oe_n_nxt = LHB_OE_ALL_ON;
            out_nxt = read_data;
            rreq_nxt = rising(rd_s, rd_d_r);
         end
         if (rising(wr_d_r, wr_s)) begin
            wv_nxt = 1'b1;
            wd_nxt = bus_s;
            wid_nxt = dc_s;
         end
      end else begin
         unique case (st_r)
            LHB_IDLE: if (rd_s) st_nxt = LHB_ACTIVE;
            LHB_ACTIVE: if (!rd_s) st_nxt = LHB_DONE;
            LHB_DONE: st_nxt = LHB_IDLE;
            default: st_nxt = LHB_IDLE;
         endcase
         if (rd_s && wr_s) begin
            oe_n_nxt = LHB_OE_ALL_ON;
            out_nxt = read_data;
            rreq_nxt = rising(rd_d_r, rd_s);
         end
         if (st_r == LHB_ACTIVE && !rd_s && !wr_s) begin
            wv_nxt = 1'b1;
            wd_nxt = bus_s;
            wid_nxt = dc_s;
         end
      end
      if (!par) begin
         oe_n_nxt = LHB_OE_ALL_OFF;
         rreq_nxt = 1'b0;
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         rd_d_r <= 1'b1;
         wr_d_r <= 1'b1;
         scl_d_r <= 1'b0;
         dot_d_r <= 1'b0;
         sh_r <= LHB_DATA_RST;
         cnt_r <= 3'h0;
         st_r <= LHB_IDLE;
         out_r <= LHB_DATA_RST;
         oe_n_r <= LHB_OE_ALL_OFF;
         rreq_r <= 1'b0;
         wv_r <= 1'b0;
         wd_r <= LHB_DATA_RST;
         wid_r <= 1'b0;
         init_r <= 1'b1;
         div_r <= 2'h0;
         dce_r <= 1'b0;
         osc_r <= 1'b0;
         slope_r <= 1'b0;
         ref_r <= 1'b0;
      end else begin
         rd_d_r <= rd_d_nxt;
         wr_d_r <= wr_d_nxt;
         scl_d_r <= scl_d_nxt;
         dot_d_r <= dot_d_nxt;
         sh_r <= sh_nxt;
         cnt_r <= cnt_nxt;
         st_r <= st_nxt;
         out_r <= out_nxt;
         oe_n_r <= oe_n_nxt;
         rreq_r <= rreq_nxt;
         wv_r <= wv_nxt;
         wd_r <= wd_nxt;
         wid_r <= wid_nxt;
         init_r <= init_nxt;
         div_r <= div_nxt;
         dce_r <= dce_nxt;
         osc_r <= osc_nxt;
         slope_r <= slope_nxt;
         ref_r <= ref_nxt;
      end
   end

   assign host_data_bus_out = out_r;
   assign host_data_bus_oe_n = oe_n_r;
   assign read_req = rreq_r;
   assign wr_valid = wv_r;
   assign wr_data = wd_r;
   assign wr_is_data = wid_r;
   assign settings_init = init_r;
   assign dot_clk_en = dce_r;
   assign osc_enable = osc_r;
   assign slope_steep = slope_r;
   assign ref_internal = ref_r;

   // checks
   a_cs_off_release: assert property (
      @(posedge clk) disable iff (rst)
      !cs_on |=> host_data_bus_oe_n == LHB_OE_ALL_OFF)
      else $error("bus driven while deselected");
   a_serial_no_drive: assert property (
      @(posedge clk) disable iff (rst)
      !par_s |=> host_data_bus_oe_n == LHB_OE_ALL_OFF)
      else $error("serial mode drove the bus");
   a_serial_no_read: assert property (
      @(posedge clk) disable iff (rst)
      !$past(par_s) |-> !read_req)
      else $error("read request in serial mode");
   a_serial_shift: assert property (
      @(posedge clk) disable iff (rst)
      (!par_s && cs_on && init_n_s && rising(scl_d_r, bus_s[LHB_SCL_BIT]))
      |=> sh_r == {$past(sh_r[6:0]), $past(bus_s[LHB_SI_BIT])})
      else $error("serial bit not shifted in");
   a_sep_read_drive: assert property (
      @(posedge clk) disable iff (rst)
      (par_s && !style_s && cs_on && init_n_s && !rd_s)
      |=> host_data_bus_oe_n == LHB_OE_ALL_ON)
      else $error("read strobe low but bus released");
   a_sep_read_data: assert property (
      @(posedge clk) disable iff (rst)
      (par_s && !style_s && cs_on && init_n_s && !rd_s)
      |=> host_data_bus_out == $past(read_data))
      else $error("read data not presented");
   a_read_single: assert property (
      @(posedge clk) disable iff (rst)
      read_req |=> !read_req)
      else $error("read request longer than one cycle");
   a_sep_write_cap: assert property (
      @(posedge clk) disable iff (rst)
      (par_s && !style_s && cs_on && init_n_s && rising(wr_d_r, wr_s))
      |=> wr_valid && wr_data == $past(bus_s))
      else $error("write strobe rise not captured");
   a_estyle_write: assert property (
      @(posedge clk) disable iff (rst)
      (par_s && style_s && cs_on && init_n_s && st_r == LHB_ACTIVE
       && !rd_s && !wr_s) |=> wr_valid && wr_data == $past(bus_s))
      else $error("enable fall not captured");
   a_estyle_dir: assert property (
      @(posedge clk) disable iff (rst)
      (par_s && style_s && cs_on && init_n_s && !wr_s)
      |=> host_data_bus_oe_n == LHB_OE_ALL_OFF)
      else $error("write direction drove the bus");
   a_init_level: assert property (
      @(posedge clk) disable iff (rst)
      !init_n_s |=> settings_init && !wr_valid)
      else $error("init level not honoured");
   a_init_clear: assert property (
      @(posedge clk) disable iff (rst)
      !init_n_s |=> cnt_r == 3'h0 && !read_req)
      else $error("init level left transfer state");
   a_dc_follow: assert property (
      @(posedge clk) disable iff (rst)
      $rose(wr_valid) |-> wr_is_data == $past(dc_s))
      else $error("data command select mismatch");
   a_osc_strap: assert property (
      @(posedge clk) disable iff (rst)
      !$past(osc_s) |-> dot_clk_en == $past(rising(dot_d_r, dot_s)))
      else $error("external dot clock not followed");
   a_dot_single: assert property (
      @(posedge clk) disable iff (rst)
      dot_clk_en |=> !dot_clk_en)
      else $error("dot clock enable longer than one cycle");
   a_slope_follow: assert property (
      @(posedge clk) disable iff (rst)
      1'b1 |=> slope_steep == $past(slope_s))
      else $error("slope strap not followed");
   a_ref_follow: assert property (
      @(posedge clk) disable iff (rst)
      1'b1 |=> ref_internal == $past(ref_s))
      else $error("reference strap not followed");
endmodule
`default_nettype wire

// *** rtl/lhb_pkg.sv ***
// constants shared by the lcd host bus front end
package lhb_pkg;
   localparam int LHB_DW = 8;
   localparam int LHB_SI_BIT = 7;
   localparam int LHB_SCL_BIT = 6;
   localparam logic [2:0] LHB_BITS_LAST = 3'h7;
   localparam logic [7:0] LHB_DATA_RST = 8'h00;
   localparam logic [7:0] LHB_OE_ALL_OFF = 8'hff;
   localparam logic [7:0] LHB_OE_ALL_ON = 8'h00;
   localparam int LHB_OSC_DIV = 4;
   typedef enum logic [1:0] {
      LHB_IDLE = 2'b00,
      LHB_ACTIVE = 2'b01,
      LHB_DONE = 2'b11
   } lhb_pstate_t;
endpackage

// *** rtl/lhb_sync.sv ***
// two flip-flop synchroniser for a vector of pin levels
`timescale 1ns/1ps
`default_nettype none
module lhb_sync #(
   parameter int W = 1
) (
   input wire logic clk,
   input wire logic rst,
   input wire logic [W-1:0] d,
   output logic [W-1:0] q
);
   logic [W-1:0] meta_r;
   logic [W-1:0] q_r;
   always_ff @(posedge clk) begin
      if (rst) begin
         meta_r <= '0;
         q_r <= '0;
      end else begin
         meta_r <= d;
         q_r <= meta_r;
      end
   end
   assign q = q_r;
endmodule
`default_nettype wire

// *** tb/lhb_host_model.sv ***
// host side model driving the controller's bus pins
`timescale 1ns/1ps
`default_nettype none
module lhb_host_model (
   input wire logic clk,
   output logic cs_n,
   output logic cs,
   output logic dcs,
   output logic rd,
   output logic wr,
   output logic [7:0] bus
);
   initial begin
      {cs_n, cs, dcs, rd, wr} = 5'h19;
      bus = 8'h00;
   end
   task automatic hold(input int n);
      repeat (n) @(posedge clk);
   endtask
   task automatic idle(input logic m);
      rd <= ~m;
      wr <= 1'b1;
      hold(6);
   endtask
   task automatic sel(input logic on, input logic a);
      cs_n <= ~on;
      cs <= on;
      dcs <= a;
   endtask
   task automatic par_wr(input logic m, input logic a, input logic [7:0] d);
      sel(1'b1, a);
      bus <= d;
      wr <= 1'b0;
      if (m) begin
         hold(6);
         rd <= 1'b1;
      end
      hold(6);
      if (m) rd <= 1'b0;
      else wr <= 1'b1;
      hold(6);
      sel(1'b0, ~a);
      bus <= ~d;
      wr <= 1'b1;
      hold(6);
   endtask
   task automatic par_rd(input logic m, input logic on);
      sel(on, 1'b1);
      wr <= 1'b1;
      rd <= m;
      hold(6);
   endtask
   task automatic rd_end(input logic m);
      rd <= ~m;
      sel(1'b0, 1'b0);
      bus <= ~bus;
      hold(6);
   endtask
   task automatic ser_wr(input logic a, input logic [7:0] d);
      sel(1'b1, a);
      for (int i = 7; i >= 0; i--) begin
         bus[7] <= d[i];
         bus[6] <= 1'b0;
         hold(10);
         bus[6] <= 1'b1;
         hold(10);
      end
      bus[6] <= 1'b0;
      hold(6);
      sel(1'b0, ~a);
      bus[7] <= ~d[0];
      hold(6);
   endtask
endmodule
`default_nettype wire

// *** tb/lcd_host_bus_interface_tb.sv ***
// self-checking bench for the lcd host bus front end
`timescale 1ns/1ps
`default_nettype none
module lcd_host_bus_interface_tb;
   import lhb_pkg::*;
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic init_low, pk, bs, osc, ts, ro, dot, read_req;
   logic [7:0] rdat;
   logic cs_n, cs, dcs, rd, wr, wr_valid, wr_is_data, settings_init;
   logic dot_clk_en, osc_enable, slope_steep, ref_internal;
   logic [7:0] hbus, bus_out, oe_n, wr_data;
   wire [7:0] bus_in = (~oe_n & bus_out) | (oe_n & hbus);
   int failures = 0;
   int total_checks = 0;
   int seed = 32'h39f3;
   int pulses = 0;
   int rreqs = 0;
   logic [8:0] wq[$];
   always #4 clk = ~clk;
   lhb_host_model lhb_host_model_i (.clk(clk), .cs_n(cs_n), .cs(cs),
      .dcs(dcs), .rd(rd), .wr(wr), .bus(hbus));
   lhb_host_if lhb_host_if_i (.clk(clk), .rst(rst), .init_low(init_low),
      .chip_select_low_active(cs_n), .chip_select_high_active(cs),
      .data_command_select(dcs), .rd_strobe(rd), .wr_strobe(wr),
      .port_kind_select(pk), .bus_style_select(bs), .osc_source_select(osc),
      .temp_slope_select(ts), .reference_origin_select(ro),
      .dot_timing_pin(dot), .host_data_bus_in(bus_in),
      .host_data_bus_out(bus_out), .host_data_bus_oe_n(oe_n),
      .read_data(rdat), .read_req(read_req), .wr_valid(wr_valid),
      .wr_data(wr_data),
      .wr_is_data(wr_is_data), .settings_init(settings_init),
      .dot_clk_en(dot_clk_en), .osc_enable(osc_enable),
      .slope_steep(slope_steep), .ref_internal(ref_internal));
   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      total_checks++;
      if (seen !== exp) begin
         failures++;
         $display("CHECK FAILED at %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic close_out;
      $display("checks %0d failures %0d", total_checks, failures);
      if (failures == 0 && total_checks > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask
   always @(posedge clk) begin
      if (dot_clk_en === 1'b1) pulses <= pulses + 1;
      if (read_req === 1'b1) rreqs <= rreqs + 1;
      if (wr_valid === 1'b1) begin
         if (wq.size() == 0) check(16'h1, 16'h0);
         else check(16'({wr_is_data, wr_data}), 16'(wq.pop_front()));
      end
   end
   initial begin
      #100000;
      failures++;
      close_out();
   end
   initial begin
      int c;
      logic [7:0] d;
      init_low <= 1'b1;
      pk <= 1'b1;
      bs <= 1'b0;
      osc <= 1'b1;
      ts <= 1'b0;
      ro <= 1'b0;
      dot <= 1'b0;
      rdat <= 8'h00;
      repeat (5) @(posedge clk);
      rst <= 1'b0;
      lhb_host_model_i.hold(4);
      for (int m = 0; m < 2; m++) begin
         bs <= m[0];
         lhb_host_model_i.idle(m[0]);
         for (int k = 0; k < 4; k++) begin
            d = 8'($random(seed));
            wq.push_back({k[0], d});
            lhb_host_model_i.par_wr(m[0], k[0], d);
         end
         rdat <= 8'($random(seed));
         lhb_host_model_i.par_rd(m[0], 1'b1);
         check(16'(oe_n), 16'(LHB_OE_ALL_ON));
         check(16'(bus_out), 16'(rdat));
         check(16'(rreqs), 16'(m + 1));
         lhb_host_model_i.rd_end(m[0]);
         lhb_host_model_i.par_rd(m[0], 1'b0);
         check(16'(oe_n), 16'(LHB_OE_ALL_OFF));
         lhb_host_model_i.rd_end(m[0]);
         $display("test parallel mode %0d done", m);
      end
      pk <= 1'b0;
      lhb_host_model_i.idle(1'b0);
      for (int k = 0; k < 3; k++) begin
         d = 8'($random(seed));
         wq.push_back({k[0], d});
         lhb_host_model_i.ser_wr(k[0], d);
      end
      lhb_host_model_i.par_rd(1'b0, 1'b1);
      check(16'(oe_n), 16'(LHB_OE_ALL_OFF));
      lhb_host_model_i.rd_end(1'b0);
      $display("test serial done");
      for (int i = 0; i < 8; i++) begin
         {osc, ts, ro} <= i[2:0];
         lhb_host_model_i.hold(6);
         check(16'({osc_enable, slope_steep, ref_internal}), 16'(i));
      end
      c = pulses;
      lhb_host_model_i.hold(40);
      check(16'(pulses - c), 16'(40 / LHB_OSC_DIV));
      osc <= 1'b0;
      lhb_host_model_i.hold(6);
      c = pulses;
      repeat (4) begin
         dot <= 1'b1;
         lhb_host_model_i.hold(10);
         dot <= 1'b0;
         lhb_host_model_i.hold(10);
      end
      check(16'(pulses - c), 16'h4);
      $display("test straps done");
      pk <= 1'b1;
      init_low <= 1'b0;
      lhb_host_model_i.idle(1'b0);
      check(16'(settings_init), 16'h1);
      lhb_host_model_i.par_wr(1'b0, 1'b1, 8'h5a);
      init_low <= 1'b1;
      lhb_host_model_i.hold(6);
      check(16'(settings_init), 16'h0);
      check(16'(wq.size()), 16'h0);
      check(16'(rreqs), 16'h2);
      $display("test init done");
      close_out();
   end
endmodule
`default_nettype wire
